// ### verilog/fccp_cycle_ctrl.v
// Functional notes
// - Skip request high suppresses every switch-on until it falls again.
// - Skip entry comes from VCO-derived skip indication, not control level.
// - Standby output set when VCO near minimum frequency.
// - Standby output cleared when VCO permits near maximum frequency.
// - Always discontinuous; no new stroke before secondary stroke ends.
// - Delayed demagnetization lengthens off-time, lowering delivered power.
// - Demagnetization ignored during fixed suppression at secondary start.
// - Overvoltage evaluated only during secondary stroke, filtered input.
// - Program pin mode: grounded off, 5 V default count, capacitor programmed.
// - Capacitor mode count is never shorter than default count.
// - Counter increments each cycle with an overvoltage event.
// - Counter decrements twice as fast in cycles without an event.
// - Threshold reached: declare overvoltage, turn power switch off.
// - After shutdown stay off through undervoltage and recharge cycles.
// - Latched shutdown clears only when supply falls below latch-reset level.
// - Cycle starts with switch on; ends at current control level.
// - After oscillator permit and demagnetization, wait for valley.
// - Peak current limit active only after leading edge blanking.
// - Mains level sampled in primary stroke adjusts peak current limit.
// - Gate drive held in per-cycle latch; one switch-on per cycle.
// - Undervoltage stops switching at once and enters safe restart.
`include "fccp_map.vh"

module fccp_cycle_ctrl #(
  parameter MIN_PERIOD_CYC = `FCCP_MIN_PERIOD_CYC,
  parameter MAX_PERIOD_CYC = `FCCP_MAX_PERIOD_CYC,
  parameter LEB_CYC        = `FCCP_LEB_CYC,
  parameter SUP_CYC        = `FCCP_SUP_CYC,
  parameter OVP_DEF_COUNT  = `FCCP_OVP_DEF_COUNT,
  parameter CNT_W          = 16,
  parameter OVP_W          = 8
) (
  input  wire             mclk_in,
  input  wire             srst_in,
  input  wire             demag_sense_in,
  input  wire             valley_in,
  input  wire             current_sense_in,
  input  wire             peak_limit_in,
  input  wire             mains_high_in,
  input  wire             overvoltage_in,
  input  wire             skip_req_in,
  input  wire             vco_near_min_in,
  input  wire             vco_near_max_in,
  input  wire             supply_ok_in,
  input  wire             latch_reset_in,
  input  wire [1:0]       overvoltage_program_pin,
  input  wire [OVP_W-1:0] ovp_cap_count_in,
  output reg              gate_drive_out,
  output reg              standby_drive_out,
  output reg              aux_five_volt_out,
  output reg              ovp_latched_out,
  output reg              peak_current_limit,
  output reg              secondary_out
);

  // ===================================================================
  // Input synchronisers
  // ===================================================================
  localparam NSYNC = 11;
  wire [NSYNC-1:0] raw_in;
  reg  [NSYNC-1:0] sync1_reg;
  reg  [NSYNC-1:0] sync2_reg;
  reg  [NSYNC-1:0] sync3_reg;
  reg  [NSYNC-1:0] stable_reg;
  assign raw_in = {latch_reset_in, supply_ok_in, vco_near_max_in, vco_near_min_in,
                   skip_req_in, overvoltage_in, mains_high_in, peak_limit_in,
                   current_sense_in, valley_in, demag_sense_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge mclk_in) begin
        if (srst_in) begin
          sync1_reg[gi]  <= 1'b0;
          sync2_reg[gi]  <= 1'b0;
          sync3_reg[gi]  <= 1'b0;
          stable_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= raw_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
          if (sync2_reg[gi] == sync3_reg[gi]) begin
            stable_reg[gi] <= sync3_reg[gi];
          end
        end
      end
    end
  endgenerate

  wire s_demag    = stable_reg[0];
  wire s_valley   = stable_reg[1];
  wire s_cur      = stable_reg[2];
  wire s_plimit   = stable_reg[3];
  wire s_mains    = stable_reg[4];
  wire s_ovp      = stable_reg[5];
  wire s_skip     = stable_reg[6];
  wire s_near_min = stable_reg[7];
  wire s_near_max = stable_reg[8];
  wire s_supply   = stable_reg[9];
  wire s_lreset   = stable_reg[10];

  // ===================================================================
  // Cycle state machine
  // ===================================================================
  localparam ST_IDLE = 3'h0;
  localparam ST_ON   = 3'h1;
  localparam ST_SUP  = 3'h2;
  localparam ST_SEC  = 3'h3;
  localparam ST_WAIT = 3'h4;

  reg [2:0]       state_reg;
  reg [2:0]       state_next;
  reg [CNT_W-1:0] tmr_reg;
  reg [CNT_W-1:0] tmr_next;
  reg [CNT_W-1:0] per_reg;
  reg [CNT_W-1:0] per_next;
  reg             mains_reg;
  reg             mains_next;
  reg             ev_reg;
  reg             ev_next;
  reg             cycle_end;
  reg [OVP_W-1:0] ovp_cnt_reg;
  reg [OVP_W-1:0] ovp_cnt_next;
  reg             ovp_latch_reg;
  reg             ovp_latch_next;

  // Counter steps sized to the counter
  localparam [OVP_W-1:0] OVP_UP = `FCCP_OVP_UP_STEP;
  localparam [OVP_W-1:0] OVP_DN = `FCCP_OVP_DN_STEP;

  wire run_ok   = s_supply & ~ovp_latch_reg;
  wire leb_done = (tmr_reg >= LEB_CYC[CNT_W-1:0]);
  wire s_mains_lat = mains_reg;
  // Overpower: high mains uses the lower of the two limit thresholds
  wire limit_hit = leb_done & (s_plimit | (s_mains_lat & s_cur));
  wire osc_ok   = (per_reg >= MIN_PERIOD_CYC[CNT_W-1:0]);

  always @* begin
    state_next = state_reg;
    tmr_next   = tmr_reg;
    per_next   = (per_reg == {CNT_W{1'b1}}) ? per_reg : per_reg + 1'b1;
    mains_next = mains_reg;
    ev_next    = ev_reg;
    cycle_end  = 1'b0;
    if (!run_ok) begin
      state_next = ST_IDLE;
      tmr_next   = {CNT_W{1'b0}};
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (!s_skip) begin
            state_next = ST_ON;
            tmr_next   = {CNT_W{1'b0}};
            per_next   = {CNT_W{1'b0}};
            mains_next = 1'b0;
          end
        end
        ST_ON: begin
          tmr_next = tmr_reg + 1'b1;
          if (!leb_done) begin
            mains_next = s_mains;
          end
          if (limit_hit || (leb_done && s_cur)) begin
            state_next = ST_SUP;
            tmr_next   = {CNT_W{1'b0}};
            ev_next    = 1'b0;
          end
        end
        ST_SUP: begin
          tmr_next = tmr_reg + 1'b1;
          if (tmr_reg >= SUP_CYC[CNT_W-1:0]) begin
            state_next = ST_SEC;
          end
        end
        ST_SEC: begin
          if (s_ovp) begin
            ev_next = 1'b1;
          end
          if (!s_demag) begin
            state_next = ST_WAIT;
            cycle_end  = 1'b1;
          end
        end
        ST_WAIT: begin
          if (osc_ok && s_valley && !s_skip) begin
            state_next = ST_ON;
            tmr_next   = {CNT_W{1'b0}};
            per_next   = {CNT_W{1'b0}};
            mains_next = 1'b0;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // ===================================================================
  // Overvoltage counter and latch
  // ===================================================================
  reg [OVP_W-1:0] ovp_limit;
  always @* begin
    case (overvoltage_program_pin)
      `FCCP_OVP_MODE_CAP: begin
        ovp_limit = (ovp_cap_count_in < OVP_DEF_COUNT[OVP_W-1:0]) ?
                    OVP_DEF_COUNT[OVP_W-1:0] : ovp_cap_count_in;
      end
      `FCCP_OVP_MODE_INT: begin
        ovp_limit = OVP_DEF_COUNT[OVP_W-1:0];
      end
      `FCCP_OVP_MODE_OFF: begin
        ovp_limit = OVP_DEF_COUNT[OVP_W-1:0];
      end
      default: begin
        ovp_limit = OVP_DEF_COUNT[OVP_W-1:0];
      end
    endcase
  end

  // Count after one more event
  wire [OVP_W-1:0] ovp_cnt_inc = ovp_cnt_reg + OVP_UP;

  wire ovp_on = (overvoltage_program_pin == `FCCP_OVP_MODE_INT) ||
                (overvoltage_program_pin == `FCCP_OVP_MODE_CAP);

  always @* begin
    ovp_cnt_next   = ovp_cnt_reg;
    ovp_latch_next = ovp_latch_reg;
    if (s_lreset) begin
      ovp_latch_next = 1'b0;
      ovp_cnt_next   = {OVP_W{1'b0}};
    end else if (!ovp_on) begin
      ovp_cnt_next = {OVP_W{1'b0}};
    end else if (cycle_end) begin
      if (ev_reg) begin
        ovp_cnt_next = ovp_cnt_inc;
        if (ovp_cnt_inc >= ovp_limit) begin
          ovp_latch_next = 1'b1;
        end
      end else if (ovp_cnt_reg >= OVP_DN) begin
        ovp_cnt_next = ovp_cnt_reg - OVP_DN;
      end else begin
        ovp_cnt_next = {OVP_W{1'b0}};
      end
    end
  end

  // ===================================================================
  // Registers and outputs
  // ===================================================================
  always @(posedge mclk_in) begin
    if (srst_in) begin
      state_reg <= ST_IDLE;
      tmr_reg   <= {CNT_W{1'b0}};
      per_reg   <= {CNT_W{1'b0}};
      mains_reg <= 1'b0;
      ev_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      tmr_reg   <= tmr_next;
      per_reg   <= per_next;
      mains_reg <= mains_next;
      ev_reg    <= ev_next;
    end
  end

  always @(posedge mclk_in) begin
    if (srst_in) begin
      ovp_cnt_reg   <= {OVP_W{1'b0}};
      ovp_latch_reg <= 1'b0;
    end else begin
      ovp_cnt_reg   <= ovp_cnt_next;
      ovp_latch_reg <= ovp_latch_next;
    end
  end

  // ===================================================================
  // Output flip-flops
  // ===================================================================
  // Gate follows ON state only, latched per cycle
  always @(posedge mclk_in) begin
    if (srst_in) begin
      gate_drive_out <= 1'b0;
    end else begin
      gate_drive_out <= run_ok && !ovp_latch_next &&
                        (state_next == ST_ON);
    end
  end

  // Near minimum sets, near maximum clears
  always @(posedge mclk_in) begin
    if (srst_in) begin
      standby_drive_out <= 1'b0;
    end else begin
      if (s_near_min) begin
        standby_drive_out <= 1'b1;
      end else if (s_near_max) begin
        standby_drive_out <= 1'b0;
      end
    end
  end

  always @(posedge mclk_in) begin
    if (srst_in) begin
      aux_five_volt_out <= 1'b0;
    end else begin
      aux_five_volt_out <= run_ok;
    end
  end

  always @(posedge mclk_in) begin
    if (srst_in) begin
      ovp_latched_out <= 1'b0;
    end else begin
      ovp_latched_out <= ovp_latch_next;
    end
  end

  // Marks on-times cut by a limit rather than the control level
  always @(posedge mclk_in) begin
    if (srst_in) begin
      peak_current_limit <= 1'b0;
    end else begin
      peak_current_limit <= (state_reg == ST_ON) && limit_hit;
    end
  end

  always @(posedge mclk_in) begin
    if (srst_in) begin
      secondary_out <= 1'b0;
    end else begin
      secondary_out <= (state_next == ST_SUP) || (state_next == ST_SEC);
    end
  end

endmodule // fccp_cycle_ctrl

// ### verilog/fccp_map.vh
`ifndef FCCP_MAP_VH
`define FCCP_MAP_VH
// =====================================================================
// Timing figures and cycle counts at 100 MHz (10 ns)
// =====================================================================
`define FCCP_CLK_PERIOD_NS   10
// Fastest switching: 125 kHz -> 8000 ns period
`define FCCP_TMIN_PERIOD_NS  8000
`define FCCP_MIN_PERIOD_CYC  (`FCCP_TMIN_PERIOD_NS / `FCCP_CLK_PERIOD_NS)
// Slowest VCO switching: 25 kHz -> 40000 ns period
`define FCCP_TMAX_PERIOD_NS  40000
`define FCCP_MAX_PERIOD_CYC  (`FCCP_TMAX_PERIOD_NS / `FCCP_CLK_PERIOD_NS)
// Leading edge blanking, least time
`define FCCP_LEB_NS          300
`define FCCP_LEB_CYC         ((`FCCP_LEB_NS + `FCCP_CLK_PERIOD_NS - 1) / `FCCP_CLK_PERIOD_NS)
// Demagnetization suppression after switch-off, least time
`define FCCP_SUP_NS          1500
`define FCCP_SUP_CYC         ((`FCCP_SUP_NS + `FCCP_CLK_PERIOD_NS - 1) / `FCCP_CLK_PERIOD_NS)
// Default count of overvoltage cycles on the up/down counter
`define FCCP_OVP_DEF_COUNT   10
// Overvoltage counter steps
`define FCCP_OVP_UP_STEP     1
`define FCCP_OVP_DN_STEP     2
// Overvoltage program pin modes
`define FCCP_OVP_MODE_OFF    2'h0
`define FCCP_OVP_MODE_INT    2'h1
`define FCCP_OVP_MODE_CAP    2'h2
`endif

// ### verification/fccp_partner.sv
// ==================
// Switch and windings
module fccp_partner #(
  parameter ON_CYC = 20
) (
  input  wire        mclk_in,
  input  wire        gate_in,
  input  wire [15:0] dem_cyc_in,
  output logic       cur_out,
  output logic       demag_out,
  output logic       valley_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int on_cnt = 0;
  int off_cnt = 0;
  always @(posedge mclk_in) begin
    on_cnt <= gate_in ? on_cnt + 1 : 0;
    off_cnt <= gate_in ? 0 : off_cnt + 1;
  end
  assign cur_out = gate_in && on_cnt >= ON_CYC;
  assign demag_out = !gate_in && off_cnt < dem_cyc_in;
  // Ringing valleys recur every 8 cycles
  assign valley_out = !gate_in && off_cnt >= dem_cyc_in && off_cnt[2];
endmodule // fccp_partner

// ### verification/fccp_cycle_ctrl_asserts.sv
module fccp_cycle_ctrl_asserts #(
  parameter MIN_PERIOD_CYC = 800
) (
  input wire mclk_in,
  input wire srst_in,
  input wire skip_req_in,
  input wire supply_ok_in,
  input wire vco_near_min_in,
  input wire vco_near_max_in,
  input wire gate_drive_out,
  input wire standby_drive_out,
  input wire aux_five_volt_out,
  input wire ovp_latched_out,
  input wire secondary_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);
  logic [15:0] gap_reg;
  always @(posedge mclk_in)
    if (srst_in)
      gap_reg <= 16'hFFFF;
    else if ($rose(gate_drive_out))
      gap_reg <= 16'h0001;
    else if (gap_reg != 16'hFFFF)
      gap_reg <= gap_reg + 16'h0001;
  sequence s_gate_on;
    $rose(gate_drive_out);
  endsequence
  sequence s_latched;
    ovp_latched_out ##1 ovp_latched_out;
  endsequence
  property p_skip;
    skip_req_in [*8] |-> !$rose(gate_drive_out);
  endproperty
  a_skip: assert property (p_skip) else $error("switch-on in skip");
  property p_blank;
    s_gate_on |=> gate_drive_out [*7];
  endproperty
  a_blank: assert property (p_blank) else $error("on-time cut in blanking");
  property p_supp;
    $rose(secondary_out) |-> secondary_out [*5];
  endproperty
  a_supp: assert property (p_supp) else $error("demag not suppressed");
  property p_disc;
    secondary_out |-> !gate_drive_out;
  endproperty
  a_disc: assert property (p_disc) else $error("switch-on in secondary");
  property p_period;
    s_gate_on |-> gap_reg >= MIN_PERIOD_CYC;
  endproperty
  a_period: assert property (p_period) else $error("second switch-on");
  property p_latch;
    s_latched |-> !gate_drive_out && !aux_five_volt_out;
  endproperty
  a_latch: assert property (p_latch) else $error("active while latched");
  property p_uvlo;
    !supply_ok_in [*8] |-> !gate_drive_out;
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("switching in undervoltage");
  property p_stby_on;
    vco_near_min_in [*8] |-> standby_drive_out;
  endproperty
  a_stby_on: assert property (p_stby_on) else $error("standby not set");
  property p_stby_off;
    (vco_near_max_in && !vco_near_min_in) [*8] |-> !standby_drive_out;
  endproperty
  a_stby_off: assert property (p_stby_off) else $error("standby not cleared");
endmodule // fccp_cycle_ctrl_asserts
bind fccp_cycle_ctrl fccp_cycle_ctrl_asserts #(
  .MIN_PERIOD_CYC(MIN_PERIOD_CYC)
) fccp_chk_inst (
  .mclk_in(mclk_in), .srst_in(srst_in), .skip_req_in(skip_req_in),
  .supply_ok_in(supply_ok_in), .vco_near_min_in(vco_near_min_in),
  .vco_near_max_in(vco_near_max_in), .gate_drive_out(gate_drive_out),
  .standby_drive_out(standby_drive_out), .aux_five_volt_out(aux_five_volt_out),
  .ovp_latched_out(ovp_latched_out), .secondary_out(secondary_out)
);

// ### verification/fccp_cycle_ctrl_tb.sv
module fccp_cycle_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MINP = 40;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sup_ok = 1'b1;
  logic        skip = 1'b0;
  logic        vmin = 1'b0;
  logic        vmax = 1'b0;
  logic        ovp = 1'b0;
  logic        lrst = 1'b0;
  logic [1:0]  mode = 2'h1;
  logic [7:0]  cap = 8'h00;
  logic [15:0] dem_cyc = 16'h001E;
  logic        plim = 1'b0;
  logic        mains = 1'b0;
  logic        gate, stby, aux, lat, sec, cur, dmg, vly, pcl;
  int          failures = 0;
  int          num_checks = 0;
  int          gap;
  fccp_cycle_ctrl #(.MIN_PERIOD_CYC(MINP), .LEB_CYC(8), .SUP_CYC(5)) fccp_cycle_ctrl_inst (
    .mclk_in(clk), .srst_in(rst), .demag_sense_in(dmg), .valley_in(vly),
    .current_sense_in(cur), .peak_limit_in(plim), .mains_high_in(mains),
    .overvoltage_in(ovp), .skip_req_in(skip), .vco_near_min_in(vmin),
    .vco_near_max_in(vmax), .supply_ok_in(sup_ok), .latch_reset_in(lrst),
    .overvoltage_program_pin(mode), .ovp_cap_count_in(cap), .gate_drive_out(gate),
    .standby_drive_out(stby), .aux_five_volt_out(aux), .ovp_latched_out(lat),
    .peak_current_limit(pcl), .secondary_out(sec));
  fccp_partner fccp_partner_inst (.mclk_in(clk), .gate_in(gate), .dem_cyc_in(dem_cyc),
    .cur_out(cur), .demag_out(dmg), .valley_out(vly));
  initial forever #5 clk = ~clk;
  // ==================
  // Shared steps
  task automatic cyc();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic rise();
    gap = 0;
    while (gate === 1'b1 && gap < 3000) begin
      cyc();
      gap++;
    end
    while (gate !== 1'b1 && gap < 3000) begin
      cyc();
      gap++;
    end
    chk(gap < 3000, 1'b1);
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (5) cyc();
    rst = 1'b0;
  endtask
  task automatic test_done();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==================
  // Scenarios
  task automatic t_cycle();
    rise();
    rise();
    chk(gap >= MINP, 1'b1);
    repeat (35) cyc();
    chk(gate, 1'b0);
    chk(sec, 1'b1);
    dem_cyc = 16'h012C;
    rise();
    rise();
    chk(gap > 300, 1'b1);
    dem_cyc = 16'h0000;
    rise();
    rise();
    chk(gap >= MINP, 1'b1);
    dem_cyc = 16'h001E;
    $display("cycle test done");
  endtask
  task automatic t_skip();
    skip = 1'b1;
    repeat (40) cyc();
    gap = 0;
    repeat (200) begin
      cyc();
      gap += int'(gate === 1'b1);
    end
    chk(gap == 0, 1'b1);
    skip = 1'b0;
    rise();
    vmin = 1'b1;
    repeat (8) cyc();
    chk(stby, 1'b1);
    vmin = 1'b0;
    vmax = 1'b1;
    repeat (8) cyc();
    chk(stby, 1'b0);
    vmax = 1'b0;
    $display("skip and standby test done");
  endtask
  task automatic t_limit();
    int hits;
    hits = 0;
    rise();
    repeat (40) begin
      cyc();
      hits += int'(pcl === 1'b1);
    end
    chk(hits == 0, 1'b1);
    mains = 1'b1;
    rise();
    rise();
    hits = 0;
    repeat (40) begin
      cyc();
      hits += int'(pcl === 1'b1);
    end
    chk(hits > 0, 1'b1);
    mains = 1'b0;
    plim = 1'b1;
    rise();
    rise();
    gap = 0;
    hits = 0;
    repeat (20) begin
      cyc();
      gap += int'(gate === 1'b1);
      hits += int'(pcl === 1'b1);
    end
    chk(gap >= 6 && gap <= 9, 1'b1);
    chk(hits > 0, 1'b1);
    plim = 1'b0;
    $display("limit test done");
  endtask
  task automatic ovp_pat(input logic [1:0] m, input logic [7:0] c, input logic [15:0] p,
                         input int n, input logic e);
    mode = m;
    cap = c;
    do_reset();
    for (int i = 0; i < n; i++) begin
      rise();
      ovp = p[i];
    end
    repeat (35) cyc();
    gap = 0;
    while (gate !== 1'b1 && lat !== 1'b1 && gap < 300) begin
      cyc();
      gap++;
    end
    ovp = 1'b0;
    chk(lat, e);
    $display("overvoltage sequence done");
  endtask
  task automatic t_latch();
    sup_ok = 1'b0;
    repeat (10) cyc();
    chk(lat, 1'b1);
    sup_ok = 1'b1;
    repeat (100) cyc();
    chk(gate | aux, 1'b0);
    sup_ok = 1'b0;
    lrst = 1'b1;
    repeat (10) cyc();
    chk(lat, 1'b0);
    lrst = 1'b0;
    sup_ok = 1'b1;
    rise();
    $display("latch test done");
  endtask
  initial begin
    #800000;
    failures++;
    test_done();
  end
  initial begin
    do_reset();
    t_cycle();
    t_skip();
    t_limit();
    ovp_pat(2'h0, 8'h00, 16'hFFFF, 12, 1'b0);
    ovp_pat(2'h3, 8'h00, 16'hFFFF, 12, 1'b0);
    ovp_pat(2'h1, 8'h00, 16'h01FF, 9, 1'b0);
    ovp_pat(2'h1, 8'h00, 16'h0DFF, 12, 1'b0);
    ovp_pat(2'h1, 8'h00, 16'h1DFF, 13, 1'b1);
    ovp_pat(2'h2, 8'h03, 16'h01FF, 9, 1'b0);
    ovp_pat(2'h2, 8'h0C, 16'h07FF, 11, 1'b0);
    ovp_pat(2'h2, 8'h0C, 16'h0FFF, 12, 1'b1);
    t_latch();
    ovp_pat(2'h1, 8'h00, 16'h03FF, 10, 1'b1);
    test_done();
  end
endmodule // fccp_cycle_ctrl_tb
